// ===== common/wsu_defines.vh
// Constants for the word shift unit
`ifndef WSU_DEFINES_VH
`define WSU_DEFINES_VH
`define WSU_W 48
`define WSU_CNT_W 6
`define WSU_OP_W 5
`define WSU_OP_NOP 5'h00
`define WSU_OP_SHIFT_LEFT_ACC 5'h01
`define WSU_OP_SHIFT_RIGHT_ACC 5'h02
`define WSU_OP_SHIFT_LEFT_ACC_NUMERIC 5'h03
`define WSU_OP_SHIFT_RIGHT_ACC_NUMERIC 5'h04
`define WSU_OP_SHIFT_LEFT_MQ 5'h05
`define WSU_OP_SHIFT_RIGHT_MQ 5'h06
`define WSU_OP_SHIFT_LEFT_MQ_NUMERIC 5'h07
`define WSU_OP_SHIFT_RIGHT_MQ_NUMERIC 5'h08
`define WSU_OP_SHIFT_RIGHT_DATA 5'h09
`define WSU_OP_SHIFT_RIGHT_DATA_NUMERIC 5'h0A
`define WSU_OP_ROTATE_RIGHT_DATA 5'h0B
`define WSU_OP_SHIFT_LEFT_PAIR 5'h0C
`define WSU_OP_SHIFT_RIGHT_PAIR 5'h0D
`define WSU_OP_SHIFT_LEFT_PAIR_NUMERIC 5'h0E
`define WSU_OP_SHIFT_RIGHT_PAIR_NUMERIC 5'h0F
`define WSU_OP_JUMP_MQ_POSITIVE_ROTL 5'h10
`define WSU_OP_JUMP_MQ_NEGATIVE_ROTL 5'h11
`define WSU_OP_JUMP_MQ_ODD_ROTR 5'h12
`define WSU_OP_JUMP_MQ_EVEN_ROTR 5'h13
`define WSU_ST_IDLE 2'h0
`define WSU_ST_RUN 2'h1
`define WSU_ST_DONE 2'h2
`endif

// ===== src/wsu_step.v
// One-position shift step of a double-length word
`include "wsu_defines.vh"
module wsu_step (
    // Operand
    input wire [95:0] din,
    input wire left,
    input wire numeric,
    input wire circ,
    input wire dbl,
    // Result
    output reg [95:0] dout,
    output reg ovf
);
    always @*
    begin
        dout = din;
        ovf = 1'b0;
        if (left)
        begin
            ovf = dbl ? (din[95] ^ din[94]) : (din[47] ^ din[46]);
            if (dbl)
                dout = {din[94:0], 1'b0};
            else if (circ)
                dout = {48'h000000000000, din[46:0], din[47]};
            else
                dout = {48'h000000000000, din[46:0], 1'b0};
        end
        else if (dbl)
        begin
            if (numeric)
                dout = {din[95], din[95], din[94:1]};
            else
                dout = {1'b0, din[95:1]};
        end
        else if (circ)
            dout = {48'h000000000000, din[0], din[47:1]};
        else if (numeric)
            dout = {48'h000000000000, din[47], din[47], din[46:1]};
        else
            dout = {48'h000000000000, 1'b0, din[47:1]};
    end
endmodule

// ===== src/wsu_top.v
// Word shift unit: shifts, quotient rotations and overflow indicator
// Contract
// - Shift distance comes from address field, zero to 63 positions.
// - Only low six address bits count, so distance is modulo 64.
// - Zero distance leaves registers unchanged, clears overflow and completes normally.
// - Registers are 48 bits; distances past 48 clear all bits out, except in pair, numeric right and circular shifts.
// - Each shift clears overflow before shifting.
// - Left shift sets overflow if sign differs from next bit any step.
// - Data register shifts only right.
// - Four conditional jumps rotate quotient register one position.
// - Positive and negative jumps rotate quotient left every time.
// - Odd and even jumps rotate quotient right every time.
// - Quotient rotating jumps leave overflow untouched.
// - Ordinary shifts and numeric left shifts fill with zero.
// - Numeric right keeps sign and enters sign copies.
// - Circular shift returns leaving bits at opposite end.
// - Accumulator and quotient shift together as one double unit.
`include "wsu_defines.vh"
module wsu_top (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Command
    input wire start,
    input wire [`WSU_OP_W-1:0] op,
    input wire [14:0] addr,
    // Register loads
    input wire load,
    input wire [`WSU_W-1:0] load_acc,
    input wire [`WSU_W-1:0] load_mq,
    input wire [`WSU_W-1:0] load_data,
    input wire ovf_clear,
    // Results
    output reg [`WSU_W-1:0] acc_r,
    output reg [`WSU_W-1:0] mq_r,
    output reg [`WSU_W-1:0] data_r,
    output reg ovf_r,
    output reg busy_r,
    output reg done_r,
    output reg jump_taken_r
);
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [`WSU_CNT_W-1:0] cnt_r;
    reg [1:0] sel_r;
    reg left_r;
    reg num_r;
    reg circ_r;
    wire dbl;
    wire [95:0] st_in;
    wire [95:0] st_out;
    wire st_ovf;
    reg [1:0] dsel;
    reg dleft;
    reg dnum;
    reg dcirc;
    reg dvalid;

    // Decode: sel 0 acc, 1 mq, 2 data, 3 pair
    always @*
    begin
        dsel = 2'h0;
        dleft = 1'b0;
        dnum = 1'b0;
        dcirc = 1'b0;
        dvalid = 1'b1;
        case (op)
            `WSU_OP_SHIFT_LEFT_ACC: dleft = 1'b1;
            `WSU_OP_SHIFT_RIGHT_ACC: dleft = 1'b0;
            `WSU_OP_SHIFT_LEFT_ACC_NUMERIC:
            begin
                dleft = 1'b1;
                dnum = 1'b1;
            end
            `WSU_OP_SHIFT_RIGHT_ACC_NUMERIC: dnum = 1'b1;
            `WSU_OP_SHIFT_LEFT_MQ:
            begin
                dsel = 2'h1;
                dleft = 1'b1;
            end
            `WSU_OP_SHIFT_RIGHT_MQ: dsel = 2'h1;
            `WSU_OP_SHIFT_LEFT_MQ_NUMERIC:
            begin
                dsel = 2'h1;
                dleft = 1'b1;
                dnum = 1'b1;
            end
            `WSU_OP_SHIFT_RIGHT_MQ_NUMERIC:
            begin
                dsel = 2'h1;
                dnum = 1'b1;
            end
            `WSU_OP_SHIFT_RIGHT_DATA: dsel = 2'h2;
            `WSU_OP_SHIFT_RIGHT_DATA_NUMERIC:
            begin
                dsel = 2'h2;
                dnum = 1'b1;
            end
            `WSU_OP_ROTATE_RIGHT_DATA:
            begin
                dsel = 2'h2;
                dcirc = 1'b1;
            end
            `WSU_OP_SHIFT_LEFT_PAIR:
            begin
                dsel = 2'h3;
                dleft = 1'b1;
            end
            `WSU_OP_SHIFT_RIGHT_PAIR: dsel = 2'h3;
            `WSU_OP_SHIFT_LEFT_PAIR_NUMERIC:
            begin
                dsel = 2'h3;
                dleft = 1'b1;
                dnum = 1'b1;
            end
            `WSU_OP_SHIFT_RIGHT_PAIR_NUMERIC:
            begin
                dsel = 2'h3;
                dnum = 1'b1;
            end
            default: dvalid = 1'b0;
        endcase
    end

    assign dbl = (sel_r == 2'h3);
    assign st_in = dbl ? {acc_r, mq_r} :
        {48'h000000000000, (sel_r == 2'h0) ? acc_r :
        (sel_r == 2'h1) ? mq_r : data_r};

    wsu_step u_step (
        .din(st_in),
        .left(left_r),
        .numeric(num_r),
        .circ(circ_r),
        .dbl(dbl),
        .dout(st_out),
        .ovf(st_ovf)
    );

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            `WSU_ST_IDLE:
                if (start && dvalid && addr[5:0] != 6'h00)
                    state_nxt = `WSU_ST_RUN;
                else if (start)
                    state_nxt = `WSU_ST_DONE;
            `WSU_ST_RUN:
                if (cnt_r == 6'h01)
                    state_nxt = `WSU_ST_DONE;
            `WSU_ST_DONE: state_nxt = `WSU_ST_IDLE;
            default: state_nxt = `WSU_ST_IDLE;
        endcase
    end

    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= `WSU_ST_IDLE;
            cnt_r <= 6'h00;
            sel_r <= 2'h0;
            left_r <= 1'b0;
            num_r <= 1'b0;
            circ_r <= 1'b0;
            acc_r <= 48'h000000000000;
            mq_r <= 48'h000000000000;
            data_r <= 48'h000000000000;
            ovf_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            jump_taken_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            done_r <= (state_nxt == `WSU_ST_DONE);
            busy_r <= (state_nxt != `WSU_ST_IDLE);
            if (state_r == `WSU_ST_IDLE && load)
            begin
                acc_r <= load_acc;
                mq_r <= load_mq;
                data_r <= load_data;
            end
            if (state_r == `WSU_ST_IDLE && ovf_clear)
                ovf_r <= 1'b0;
            if (state_r == `WSU_ST_IDLE && start)
            begin
                sel_r <= dsel;
                left_r <= dleft;
                num_r <= dnum;
                circ_r <= dcirc;
                cnt_r <= addr[5:0];
                jump_taken_r <= 1'b0;
                if (dvalid)
                    ovf_r <= 1'b0;
                case (op)
                    `WSU_OP_JUMP_MQ_POSITIVE_ROTL:
                    begin
                        jump_taken_r <= ~mq_r[47];
                        mq_r <= {mq_r[46:0], mq_r[47]};
                    end
                    `WSU_OP_JUMP_MQ_NEGATIVE_ROTL:
                    begin
                        jump_taken_r <= mq_r[47];
                        mq_r <= {mq_r[46:0], mq_r[47]};
                    end
                    `WSU_OP_JUMP_MQ_ODD_ROTR:
                    begin
                        jump_taken_r <= mq_r[0];
                        mq_r <= {mq_r[0], mq_r[47:1]};
                    end
                    `WSU_OP_JUMP_MQ_EVEN_ROTR:
                    begin
                        jump_taken_r <= ~mq_r[0];
                        mq_r <= {mq_r[0], mq_r[47:1]};
                    end
                    default: jump_taken_r <= 1'b0;
                endcase
            end
            // One position per cycle
            if (state_r == `WSU_ST_RUN)
            begin
                cnt_r <= cnt_r - 6'h01;
                if (st_ovf)
                    ovf_r <= 1'b1;
                case (sel_r)
                    2'h0: acc_r <= st_out[47:0];
                    2'h1: mq_r <= st_out[47:0];
                    2'h2: data_r <= st_out[47:0];
                    default:
                    begin
                        acc_r <= st_out[95:48];
                        mq_r <= st_out[47:0];
                    end
                endcase
            end
        end
    end
endmodule

// ===== testbench/word_shift_unit_test.sv
// Self-checking testbench for the word shift unit
`include "wsu_defines.vh"
module word_shift_unit_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, rstn, start, load, ovf_clear;
    logic [4:0] op;
    logic [14:0] addr;
    logic [47:0] load_acc, load_mq, load_data, acc_r, mq_r, data_r;
    logic ovf_r, busy_r, done_r, jump_taken_r;
    int n_fail, check_count, c;
    wsu_top DUT (.core_clk(core_clk), .rstn(rstn), .start(start),
        .op(op), .addr(addr), .load(load), .load_acc(load_acc),
        .load_mq(load_mq), .load_data(load_data), .ovf_clear(ovf_clear),
        .acc_r(acc_r), .mq_r(mq_r), .data_r(data_r), .ovf_r(ovf_r),
        .busy_r(busy_r), .done_r(done_r), .jump_taken_r(jump_taken_r));
    wsu_ctl_model u_ctl (.core_clk(core_clk), .done_r(done_r),
        .start(start), .op(op), .addr(addr));
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic ld(input logic [47:0] a, q, d);
        @(posedge core_clk);
        #1;
        load = 1'b1;
        load_acc = a;
        load_mq = q;
        load_data = d;
        @(posedge core_clk);
        #1;
        load = 1'b0;
    endtask
    task automatic go(input logic [4:0] o, input logic [14:0] a);
        u_ctl.issue(o, a, c);
        chk(48'(c < 80), 48'h1);
    endtask
    task automatic t_right();
        ld(48'h800000000001, 48'h0, 48'h0);
        go(`WSU_OP_SHIFT_RIGHT_ACC, 15'h0002);
        chk(48'(c), 48'h3);
        chk(acc_r, 48'h200000000000);
        go(`WSU_OP_SHIFT_RIGHT_ACC, 15'h008F);
        chk(48'(c), 48'h10);
        chk(acc_r, 48'h000040000000);
        ld(48'h800000000000, 48'h0, 48'h0);
        go(`WSU_OP_SHIFT_RIGHT_ACC_NUMERIC, 15'h0003);
        chk(acc_r, 48'hF00000000000);
    endtask
    task automatic t_left();
        ld(48'h400000000000, 48'h0, 48'h0);
        go(`WSU_OP_SHIFT_LEFT_ACC, 15'h0001);
        chk({acc_r[46:0], ovf_r}, 48'h000000000001);
        go(`WSU_OP_SHIFT_LEFT_ACC_NUMERIC, 15'h0040);
        chk({acc_r[47], ovf_r, 46'(c)}, 48'h800000000001);
        go(`WSU_OP_SHIFT_LEFT_ACC_NUMERIC, 15'h0032);
        chk({acc_r[46:0], ovf_r}, 48'h000000000001);
    endtask
    task automatic t_data();
        ld(48'h1, 48'h0, 48'h800000000001);
        go(`WSU_OP_ROTATE_RIGHT_DATA, 15'h0004);
        chk(data_r, 48'h180000000000);
        go(`WSU_OP_SHIFT_RIGHT_DATA_NUMERIC, 15'h0001);
        chk(data_r, 48'h0C0000000000);
        chk(acc_r, 48'h1);
    endtask
    task automatic t_pair();
        ld(48'h1, 48'h0, 48'h0);
        go(`WSU_OP_SHIFT_RIGHT_PAIR, 15'h0001);
        chk(mq_r ^ acc_r, 48'h800000000000);
        go(`WSU_OP_SHIFT_LEFT_PAIR, 15'h0001);
        chk(acc_r, 48'h1);
        ld(48'h800000000000, 48'h0, 48'h0);
        go(`WSU_OP_SHIFT_RIGHT_PAIR_NUMERIC, 15'h0002);
        chk(acc_r | mq_r, 48'hE00000000000);
        go(`WSU_OP_SHIFT_RIGHT_PAIR, 15'h0001);
        chk(acc_r, 48'h700000000000);
    endtask
    task automatic t_mq();
        ld(48'h0, 48'hC00000000001, 48'h800000000000);
        go(`WSU_OP_SHIFT_LEFT_MQ, 15'h0001);
        chk(mq_r, 48'h800000000002);
        go(`WSU_OP_SHIFT_RIGHT_MQ_NUMERIC, 15'h0001);
        chk(mq_r, 48'hC00000000001);
        go(`WSU_OP_SHIFT_RIGHT_MQ, 15'h0001);
        chk(mq_r, 48'h600000000000);
        go(`WSU_OP_SHIFT_LEFT_MQ_NUMERIC, 15'h0001);
        chk(mq_r, 48'hC00000000000);
        chk(48'(ovf_r), 48'h1);
        go(`WSU_OP_SHIFT_RIGHT_DATA, 15'h0004);
        chk(data_r, 48'h080000000000);
        chk(48'(ovf_r), 48'h0);
        go(`WSU_OP_SHIFT_LEFT_PAIR_NUMERIC, 15'h0001);
        chk(acc_r, 48'h1);
        chk(mq_r, 48'h800000000000);
    endtask
    task automatic t_jump();
        logic [4:0] ops [4] = '{`WSU_OP_JUMP_MQ_POSITIVE_ROTL,
            `WSU_OP_JUMP_MQ_ODD_ROTR, `WSU_OP_JUMP_MQ_NEGATIVE_ROTL,
            `WSU_OP_JUMP_MQ_EVEN_ROTR};
        ld(48'h400000000000, 48'h800000000001, 48'h0);
        go(`WSU_OP_SHIFT_LEFT_ACC, 15'h0001);
        for (int i = 0; i < 4; i++)
        begin
            go(ops[i], 15'h0000);
            chk({ovf_r, jump_taken_r, 46'(c)}, {2'h2 | 2'(i == 1 ||
                i == 2), 46'h1});
            chk(mq_r, i[0] ? 48'h800000000001 : 48'h3);
        end
        @(posedge core_clk);
        #1;
        ovf_clear = 1'b1;
        @(posedge core_clk);
        #1;
        ovf_clear = 1'b0;
        chk(48'(ovf_r), 48'h0);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial
    begin
        #20000;
        n_fail++;
        final_report();
    end
    initial
    begin
        {rstn, load, ovf_clear, load_acc, load_mq, load_data} = '0;
        repeat (8) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        t_right();
        t_left();
        t_data();
        t_pair();
        t_mq();
        t_jump();
        final_report();
    end
endmodule

// ===== testbench/wsu_ctl_model.sv
// Sequencer model that issues instructions to the shift unit
module wsu_ctl_model (
    // Clock and status
    input logic core_clk,
    input logic done_r,
    // Command
    output logic start,
    output logic [4:0] op,
    output logic [14:0] addr
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        start = 1'b0;
        op = 5'h00;
        addr = 15'h0000;
    end
    // Issue one instruction, count cycles to completion
    task automatic issue(input logic [4:0] o, input logic [14:0] a,
        output int cyc);
        @(posedge core_clk);
        #1;
        start = 1'b1;
        op = o;
        addr = a;
        @(posedge core_clk);
        #1;
        start = 1'b0;
        op = ~o;
        addr = ~a;
        cyc = 1;
        while (done_r !== 1'b1 && cyc < 80)
        begin
            @(posedge core_clk);
            #1;
            cyc++;
        end
        @(posedge core_clk);
        #1;
    endtask
endmodule

// ===== testbench/wsu_top_chk.sv
// Assertion checker for the word shift unit
module wsu_top_chk (
    // Clock, reset, command
    input logic core_clk,
    input logic rstn,
    input logic start,
    input logic [4:0] op,
    input logic [14:0] addr,
    // Results
    input logic [47:0] acc_r,
    input logic [47:0] mq_r,
    input logic [47:0] data_r,
    input logic ovf_r,
    input logic busy_r,
    input logic done_r,
    input logic jump_taken_r
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    logic take, shf, jmp;
    assign take = start && !busy_r;
    assign shf = take && op >= 5'h01 && op <= 5'h0F;
    assign jmp = take && op >= 5'h10 && op <= 5'h13;
    chk_jump_one_cycle: assert property (jmp |=> done_r)
        else $error("jump not done in one cycle");
    chk_shift_clears_ovf: assert property (shf |=> !ovf_r)
        else $error("overflow not cleared");
    chk_jump_keeps_ovf: assert property (jmp |=> $stable(ovf_r))
        else $error("jump changed overflow");
    chk_jump_rot_left: assert property (jmp && !op[1] |=>
        mq_r == {$past(mq_r[46:0]), $past(mq_r[47])})
        else $error("bad left rotation");
    chk_jump_rot_right: assert property (jmp && op[1] |=>
        mq_r == {$past(mq_r[0]), $past(mq_r[47:1])})
        else $error("bad right rotation");
    chk_odd_test_pre: assert property (jmp && op == 5'h12 |=>
        jump_taken_r == $past(mq_r[0]))
        else $error("odd test on rotated value");
    chk_zero_dist_noop: assert property (shf && addr[5:0] == 6'h00 |=>
        done_r && $stable(acc_r) && $stable(mq_r) && $stable(data_r))
        else $error("zero distance changed state");
    chk_dist_one_time: assert property (shf && addr[5:0] == 6'h01 |=>
        busy_r && !done_r ##1 done_r)
        else $error("distance one timing wrong");
    cover property (shf && addr[5:0] == 6'h00);
    cover property (jmp && op[1]);
    cover property (shf && op == 5'h01 ##[1:70] ovf_r);
endmodule

bind wsu_top wsu_top_chk u_chk (.core_clk(core_clk), .rstn(rstn),
    .start(start), .op(op), .addr(addr), .acc_r(acc_r), .mq_r(mq_r),
    .data_r(data_r), .ovf_r(ovf_r), .busy_r(busy_r), .done_r(done_r),
    .jump_taken_r(jump_taken_r));
